/* core/debugger_control_status_regs.sv */
// Notes on behaviour
// [RULE1] The debug mode flag at 1 holds the device in debug mode, at 0 normal.
// [RULE2] In debug mode the CPU stops fetching and stays halted.
// [RULE3] Writing 0 to the debug mode flag lets the CPU run again.
// [RULE4] With read protection active a write of 0 to the flag is ignored.
// [RULE5] With breakpoints disabled the breakpoint opcode acts as a no-op.
// [RULE6] With breakpoints enabled a decoded breakpoint sets debug mode.
// [RULE7] With acknowledge enabled a taken breakpoint sends one FFh byte.
// [RULE8] Reserved bits of both registers read as zero.
// [RULE9] Status is read-only and live; its top bit shows debug mode.
// [RULE10] Status bit 6 shows that the CPU is in halt mode.
// [RULE11] Status bit 5 is 0 when read protection can gate debug commands.
// [RULE12] The host writes 81h, 41h or 40h for stop, go or run.
// [RULE13] Writing 1 to control bit 0 starts a device reset and self-clears.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module debugger_control_status_regs #(
    parameter int unsigned RESET_PULSE_CYCLES =
        dbg_ctl_pkg::RESET_PULSE_CYCLES
) (
    input  wire logic                 clk,            // 250 MHz clock
    input  wire logic                 sys_rst,        // Async reset
    input  wire dbg_ctl_pkg::reg_req_s req,           // Register request
    output logic [7:0]                rd_data,        // Read data
    input  wire dbg_ctl_pkg::opcode_s opcode,         // Decoded opcode
    input  wire logic                 halt_mode,      // CPU halted
    input  wire logic                 read_protect_option, // Option set
    input  wire logic                 read_protect_gate,   // May gate
    output logic                      fetch_stop,     // CPU stop fetch
    output logic                      bp_enable,      // Break not no-op
    output logic                      ack_valid,      // Ack byte pulse
    output logic [7:0]                ack_data,       // Ack byte value
    output logic                      device_reset,   // Device reset
    output logic                      irq             // Level interrupt
);

    // Breakpoint opcode match, used in logic and checks
    function automatic logic is_breakpoint(input dbg_ctl_pkg::opcode_s op);
        return op.valid && (op.code == dbg_ctl_pkg::BREAKPOINT_OPCODE);
    endfunction

    logic                          debug_mode_reg;
    logic                          debug_mode_next;
    logic                          bp_enable_reg;
    logic                          bp_enable_next;
    logic                          ack_enable_reg;
    logic                          ack_enable_next;
    logic                          reset_req_reg;
    logic                          reset_req_next;
    logic [dbg_ctl_pkg::EVT_W-1:0] evt_stat_reg;
    logic [dbg_ctl_pkg::EVT_W-1:0] evt_stat_next;
    logic [dbg_ctl_pkg::EVT_W-1:0] evt_mask_reg;
    logic [dbg_ctl_pkg::EVT_W-1:0] evt_mask_next;
    logic [dbg_ctl_pkg::EVT_W-1:0] evt_now;
    logic [7:0]                    rd_data_reg;
    logic [7:0]                    rd_data_next;
    logic                          ack_valid_reg;
    logic                          ack_valid_next;
    logic [7:0]                    ack_data_reg;
    logic [7:0]                    ack_data_next;
    logic                          irq_reg;
    logic                          irq_next;
    logic                          ctrl_wr;
    logic                          protect;
    logic                          bp_hit;
    logic [7:0]                    ctrl_view;
    logic [7:0]                    stat_view;

    // Decode of the request and the live conditions
    assign ctrl_wr = req.wr && (req.addr == dbg_ctl_pkg::OFS_CTRL);
    assign protect = read_protect_option && read_protect_gate;
    assign bp_hit  = is_breakpoint(opcode) && bp_enable_reg; // RULE6

    // Control register and its side effects
    always_comb
    begin
        debug_mode_next = debug_mode_reg;
        bp_enable_next  = bp_enable_reg;
        ack_enable_next = ack_enable_reg;
        reset_req_next  = 1'b0; // RULE13
        if (ctrl_wr)
        begin
            bp_enable_next  = req.wdata[dbg_ctl_pkg::CTRL_BP_ENABLE_BIT];
            ack_enable_next = req.wdata[dbg_ctl_pkg::CTRL_ACK_ENABLE_BIT];
            reset_req_next  = req.wdata[dbg_ctl_pkg::CTRL_RESET_BIT]; // RULE13
            if (req.wdata[dbg_ctl_pkg::CTRL_DEBUG_MODE_BIT])
                debug_mode_next = 1'b1; // RULE1
            else if (!protect)
                debug_mode_next = 1'b0; // RULE3 RULE4
        end
        // Breakpoint entry wins over a clearing write in the same cycle
        if (bp_hit)
            debug_mode_next = 1'b1; // RULE6
    end

    // Control state registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            debug_mode_reg <=
                dbg_ctl_pkg::CTRL_RESET_VAL[dbg_ctl_pkg::CTRL_DEBUG_MODE_BIT];
            bp_enable_reg  <=
                dbg_ctl_pkg::CTRL_RESET_VAL[dbg_ctl_pkg::CTRL_BP_ENABLE_BIT];
            ack_enable_reg <=
                dbg_ctl_pkg::CTRL_RESET_VAL[dbg_ctl_pkg::CTRL_ACK_ENABLE_BIT];
            reset_req_reg  <=
                dbg_ctl_pkg::CTRL_RESET_VAL[dbg_ctl_pkg::CTRL_RESET_BIT];
        end
        else
        begin
            debug_mode_reg <= debug_mode_next;
            bp_enable_reg  <= bp_enable_next;
            ack_enable_reg <= ack_enable_next;
            reset_req_reg  <= reset_req_next;
        end
    end

    // Acknowledge byte goes out one cycle after the breakpoint
    always_comb
    begin
        ack_valid_next = bp_hit && ack_enable_reg; // RULE7
        ack_data_next  = dbg_ctl_pkg::ACK_CHAR; // RULE7
    end

    // Acknowledge registers; the byte is a flop so the pin has no logic
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ack_valid_reg <= 1'b0;
            ack_data_reg  <= dbg_ctl_pkg::ACK_CHAR;
        end
        else
        begin
            ack_valid_reg <= ack_valid_next;
            ack_data_reg  <= ack_data_next;
        end
    end

    // Events seen this cycle
    always_comb
    begin
        evt_now = '0;
        evt_now[dbg_ctl_pkg::EVT_BREAK_BIT] = bp_hit;
        evt_now[dbg_ctl_pkg::EVT_ENTER_BIT] =
            !debug_mode_reg && debug_mode_next;
        evt_now[dbg_ctl_pkg::EVT_EXIT_BIT]  =
            debug_mode_reg && !debug_mode_next;
        evt_now[dbg_ctl_pkg::EVT_RESET_BIT] = reset_req_next;
    end

    // Sticky events clear on read; a new event wins over the clear
    always_comb
    begin
        evt_stat_next = evt_stat_reg;
        evt_mask_next = evt_mask_reg;
        if (req.rd && (req.addr == dbg_ctl_pkg::OFS_EVT_STAT))
            evt_stat_next = '0;
        evt_stat_next = evt_stat_next | evt_now;
        if (req.wr && (req.addr == dbg_ctl_pkg::OFS_EVT_MASK))
            evt_mask_next = req.wdata[dbg_ctl_pkg::EVT_W-1:0];
        irq_next = |(evt_stat_next & evt_mask_next);
    end

    // Interrupt registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            evt_stat_reg <= dbg_ctl_pkg::EVT_RESET_VAL;
            evt_mask_reg <= dbg_ctl_pkg::EVT_RESET_VAL;
            irq_reg      <= 1'b0;
        end
        else
        begin
            evt_stat_reg <= evt_stat_next;
            evt_mask_reg <= evt_mask_next;
            irq_reg      <= irq_next;
        end
    end

    // Readable views; reserved bits stay zero
    always_comb
    begin
        ctrl_view = '0; // RULE8
        ctrl_view[dbg_ctl_pkg::CTRL_DEBUG_MODE_BIT] = debug_mode_reg;
        ctrl_view[dbg_ctl_pkg::CTRL_BP_ENABLE_BIT]  = bp_enable_reg;
        ctrl_view[dbg_ctl_pkg::CTRL_ACK_ENABLE_BIT] = ack_enable_reg;
        ctrl_view[dbg_ctl_pkg::CTRL_RESET_BIT]      = reset_req_reg;
        stat_view = dbg_ctl_pkg::STAT_RESET_VAL; // RULE8
        stat_view[dbg_ctl_pkg::STAT_DEBUG_BIT]   = debug_mode_reg; // RULE9
        stat_view[dbg_ctl_pkg::STAT_HALT_BIT]    = halt_mode; // RULE10
        stat_view[dbg_ctl_pkg::STAT_RP_GATE_BIT] =
            !read_protect_gate; // RULE11
    end

    // Read mux; unmapped reads cannot occur with a 2-bit address
    always_comb
    begin
        rd_data_next = 8'h00;
        if (req.rd)
        begin
            case (req.addr)
                dbg_ctl_pkg::OFS_CTRL:     rd_data_next = ctrl_view;
                dbg_ctl_pkg::OFS_STAT:     rd_data_next = stat_view; // RULE9
                dbg_ctl_pkg::OFS_EVT_STAT:
                    rd_data_next = {4'h0, evt_stat_reg};
                dbg_ctl_pkg::OFS_EVT_MASK:
                    rd_data_next = {4'h0, evt_mask_reg};
                default:                   rd_data_next = 8'h00;
            endcase
        end
    end

    // Read data register, valid only the cycle after the strobe
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rd_data_reg <= 8'h00;
        else
            rd_data_reg <= rd_data_next;
    end

    // Reset stretcher so the rest of the chip sees a clean pulse
    device_reset_pulser #(
        .PULSE_CYCLES (RESET_PULSE_CYCLES)
    ) u_reset_pulser (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .start        (reset_req_reg), // RULE13
        .device_reset (device_reset)
    );

    // Outputs straight from flip-flops
    assign rd_data    = rd_data_reg;
    assign fetch_stop = debug_mode_reg; // RULE2
    assign bp_enable  = bp_enable_reg; // RULE5
    assign ack_valid  = ack_valid_reg;
    assign ack_data   = ack_data_reg; // RULE7
    assign irq        = irq_reg;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence seq_reset_write;
        ctrl_wr && req.wdata[dbg_ctl_pkg::CTRL_RESET_BIT];
    endsequence

    sequence seq_reset_pulse;
        reset_req_reg ##1 (!reset_req_reg || $past(reset_req_next))
            && device_reset;
    endsequence

    sequence seq_stop_write;
        ctrl_wr && req.wdata[dbg_ctl_pkg::CTRL_DEBUG_MODE_BIT];
    endsequence

    AST_STOP_WRITE_HALTS: assert property ( // RULE1
        seq_stop_write |=> fetch_stop && (ack_data == 8'hFF))
        else $error("debug mode write did not stop fetching");

    AST_DEBUG_HOLDS_FETCH_STOP: assert property ( // RULE2
        fetch_stop && !ctrl_wr |=> fetch_stop)
        else $error("fetch stop dropped without a write");

    AST_RESUME_ON_CLEAR: assert property ( // RULE3
        ctrl_wr && !req.wdata[dbg_ctl_pkg::CTRL_DEBUG_MODE_BIT]
        && !protect && !bp_hit |=> !fetch_stop)
        else $error("clearing debug mode did not resume the cpu");

    AST_PROTECT_KEEPS_DEBUG: assert property ( // RULE4
        fetch_stop && protect && ctrl_wr |=> fetch_stop)
        else $error("protected debug mode was cleared by a write");

    AST_BP_DISABLED_NOP: assert property ( // RULE5
        is_breakpoint(opcode) && !bp_enable && !fetch_stop && !ctrl_wr
        |=> !fetch_stop && !ack_valid)
        else $error("disabled breakpoint changed the debug state");

    AST_BP_ENTERS_DEBUG: assert property ( // RULE6
        is_breakpoint(opcode) && bp_enable |=> fetch_stop
        && evt_stat_reg[dbg_ctl_pkg::EVT_BREAK_BIT])
        else $error("enabled breakpoint did not enter debug mode");

    AST_ACK_ONLY_ON_BREAK: assert property ( // RULE7
        ack_valid |-> $past(is_breakpoint(opcode))
        && $past(bp_enable) && $past(ack_enable_reg))
        else $error("acknowledge byte without an enabled breakpoint");

    AST_ACK_SENT: assert property ( // RULE7
        bp_hit && ack_enable_reg |=> ack_valid ##1 !ack_valid || $past(bp_hit))
        else $error("acknowledge byte missing after breakpoint");

    AST_RESERVED_ZERO: assert property ( // RULE8
        req.rd && (req.addr == dbg_ctl_pkg::OFS_CTRL
        || req.addr == dbg_ctl_pkg::OFS_STAT)
        |=> (rd_data[4:1] == 4'h0)
        && ($past(req.addr) == dbg_ctl_pkg::OFS_CTRL || rd_data[0] == 1'b0))
        else $error("reserved bits read as nonzero");

    AST_STATUS_LIVE: assert property ( // RULE9
        req.rd && req.addr == dbg_ctl_pkg::OFS_STAT
        |=> rd_data[7] == $past(debug_mode_reg))
        else $error("status debug bit does not match debug mode");

    AST_STATUS_HALT: assert property ( // RULE10
        req.rd && req.addr == dbg_ctl_pkg::OFS_STAT
        |=> rd_data[6] == $past(halt_mode))
        else $error("status halt bit does not match cpu halt");

    AST_STATUS_GATE: assert property ( // RULE11
        req.rd && req.addr == dbg_ctl_pkg::OFS_STAT
        |=> rd_data[5] == !$past(read_protect_gate))
        else $error("status gate bit has wrong sense");

    AST_RESET_SELF_CLEARS: assert property ( // RULE13
        seq_reset_write |=> seq_reset_pulse)
        else $error("reset bit did not pulse and self clear");

    AST_ENTRY_HAS_CAUSE: assert property ( // RULE1
        !fetch_stop ##1 fetch_stop |-> $past(bp_hit)
        || $past(ctrl_wr && req.wdata[dbg_ctl_pkg::CTRL_DEBUG_MODE_BIT]))
        else $error("debug mode entered with no write or breakpoint");

    AST_BP_ENABLE_WRITE: assert property ( // RULE5
        ctrl_wr |=> bp_enable
        == $past(req.wdata[dbg_ctl_pkg::CTRL_BP_ENABLE_BIT]))
        else $error("breakpoint enable does not follow the write");

    AST_ACK_ONE_CYCLE: assert property ( // RULE7
        ack_valid && !bp_hit |=> !ack_valid)
        else $error("acknowledge strobe longer than one cycle");

    AST_STATUS_READ_ONLY: assert property ( // RULE9
        req.wr && req.addr == dbg_ctl_pkg::OFS_STAT && !bp_hit
        |=> $stable(fetch_stop) && $stable(bp_enable))
        else $error("write to status changed the control state");

    AST_RESET_BIT_CLEARS: assert property ( // RULE13
        reset_req_reg && !ctrl_wr |=> !reset_req_reg)
        else $error("reset request bit did not clear itself");

    AST_RESET_HAS_CAUSE: assert property ( // RULE13
        !device_reset ##1 device_reset |-> $past(reset_req_reg))
        else $error("device reset pulse with no request");

endmodule // debugger_control_status_regs

`default_nettype wire

/* core/dbg_ctl_pkg.sv */
package dbg_ctl_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 2'h0;
    localparam logic [ADDR_W-1:0] OFS_STAT     = 2'h1;
    localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 2'h2;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 2'h3;

    // Control register field positions
    localparam int unsigned CTRL_DEBUG_MODE_BIT = 7;
    localparam int unsigned CTRL_BP_ENABLE_BIT  = 6;
    localparam int unsigned CTRL_ACK_ENABLE_BIT = 5;
    localparam int unsigned CTRL_RESET_BIT      = 0;

    // Status register field positions
    localparam int unsigned STAT_DEBUG_BIT   = 7;
    localparam int unsigned STAT_HALT_BIT    = 6;
    localparam int unsigned STAT_RP_GATE_BIT = 5;

    // Values after reset
    localparam logic [DATA_W-1:0] CTRL_RESET_VAL = 8'h00;
    localparam logic [DATA_W-1:0] STAT_RESET_VAL = 8'h00;

    // Event status bits
    localparam int unsigned EVT_W         = 4;
    localparam int unsigned EVT_BREAK_BIT = 0;
    localparam int unsigned EVT_ENTER_BIT = 1;
    localparam int unsigned EVT_EXIT_BIT  = 2;
    localparam int unsigned EVT_RESET_BIT = 3;
    localparam logic [EVT_W-1:0] EVT_RESET_VAL = 4'h0;

    // Opcode and acknowledge character
    localparam logic [7:0] BREAKPOINT_OPCODE = 8'h00;
    localparam logic [7:0] ACK_CHAR          = 8'hFF;

    // Device reset pulse length
    localparam int unsigned CLK_PERIOD_PS  = 4000;
    localparam int unsigned RESET_PULSE_NS = 40;
    localparam int unsigned RESET_PULSE_CYCLES =
        (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_s;

    // Decoded opcode from the CPU
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } opcode_s;

endpackage

/* core/device_reset_pulser.sv */
`timescale 1ns/1ps
`default_nettype none

module device_reset_pulser #(
    parameter int unsigned PULSE_CYCLES = dbg_ctl_pkg::RESET_PULSE_CYCLES
) (
    input  wire logic clk,          // System clock
    input  wire logic sys_rst,      // Async reset, active high
    input  wire logic start,        // One-cycle request
    output logic      device_reset  // Stretched reset pulse
);

    localparam int unsigned CNT_W = $clog2(PULSE_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(PULSE_CYCLES - 1);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             active_reg;
    logic             active_next;

    // A new start while busy restarts the count
    always_comb
    begin
        cnt_next    = cnt_reg;
        active_next = active_reg;
        if (start)
        begin
            cnt_next    = '0;
            active_next = 1'b1;
        end
        else if (active_reg)
        begin
            if (cnt_reg == LAST)
                active_next = 1'b0;
            else
                cnt_next = cnt_reg + CNT_W'(1);
        end
    end

    // State registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_reg    <= '0;
            active_reg <= 1'b0;
        end
        else
        begin
            cnt_reg    <= cnt_next;
            active_reg <= active_next;
        end
    end

    assign device_reset = active_reg;

endmodule // device_reset_pulser

`default_nettype wire

/* sim/debug_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module debug_host_model (
    input  wire logic       clk,        // System clock
    input  wire logic       sys_rst,    // Async reset, active high
    input  wire logic       ack_valid,  // Byte strobe from debugger
    input  wire logic [7:0] ack_data,   // Byte from debugger
    output logic [7:0]      ack_count   // Acknowledge bytes received
);

    // Host counts only the FFh character; other bytes are not an ack
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ack_count <= 8'h00;
        else if (ack_valid && ack_data == 8'hFF)
            ack_count <= ack_count + 8'h01;
    end

endmodule // debug_host_model

`default_nettype wire

/* sim/debugger_control_status_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    $display("mismatch %s exp %0h got %0h", nm, e, g); failures++; end end

module debugger_control_status_regs_test;

    localparam int unsigned RST_CYC = 2;  // Short pulse keeps runs brief

    logic                  clk = 1'b0;
    logic                  sys_rst = 1'b1;
    dbg_ctl_pkg::reg_req_s req = '0;
    dbg_ctl_pkg::opcode_s  op = '0;
    logic                  halt = 1'b0;
    logic                  rpo = 1'b0;
    logic                  gate = 1'b0;
    logic [7:0]            rd_data;
    logic                  fetch_stop;
    logic                  bp_enable;
    logic                  ack_valid;
    logic [7:0]            ack_data;
    logic                  device_reset;
    logic                  irq;
    logic [7:0]            ack_count;
    logic [7:0]            rd_q[$];
    logic [7:0]            ack_q[$];
    logic [7:0]            exp_v;
    logic                  rd_due = 1'b0;
    logic                  dbg = 1'b0;
    logic                  bpe = 1'b0;
    logic                  acke = 1'b0;
    logic [3:0]            ev = 4'h0;
    logic [7:0]            n_acks = 8'h00;
    int                    failures = 0;
    int                    n_tests = 0;
    int                    run_len = 0;
    int                    last_len = 0;
    int                    pulses = 0;
    int                    exp_pulses = 0;
    int                    seed = 46;

    debugger_control_status_regs #(
        .RESET_PULSE_CYCLES (RST_CYC)
    ) i_debugger_control_status_regs (
        .clk                 (clk),
        .sys_rst             (sys_rst),
        .req                 (req),
        .rd_data             (rd_data),
        .opcode              (op),
        .halt_mode           (halt),
        .read_protect_option (rpo),
        .read_protect_gate   (gate),
        .fetch_stop          (fetch_stop),
        .bp_enable           (bp_enable),
        .ack_valid           (ack_valid),
        .ack_data            (ack_data),
        .device_reset        (device_reset),
        .irq                 (irq)
    );

    debug_host_model i_debug_host_model (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .ack_valid (ack_valid),
        .ack_data  (ack_data),
        .ack_count (ack_count)
    );

    always #2 clk = ~clk;

    // Monitor: read data and ack bytes are taken off the queues as they show
    always @(posedge clk)
    begin
        if (rd_due)
        begin
            exp_v = rd_q.pop_front();
            `CHK("rd_data", exp_v, rd_data)
        end
        else if (!sys_rst)
            `CHK("rd_idle", 8'h00, rd_data)
        if (ack_valid === 1'b1)
        begin
            exp_v = (ack_q.size() != 0) ? ack_q.pop_front() : 8'h00;
            `CHK("ack_data", exp_v, ack_data)
        end
        if (device_reset === 1'b1)
            run_len++;
        else if (run_len != 0)
        begin
            last_len = run_len;
            run_len = 0;
            pulses++;
        end
        rd_due <= req.rd && !sys_rst;
    end

    task automatic print_verdict();
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One-cycle write; the idle edge after it keeps strobes apart
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_q.push_back(e);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
    endtask

    task automatic chk_out();
        `CHK("fetch_stop", dbg, fetch_stop)
        `CHK("bp_enable", bpe, bp_enable)
        `CHK("irq", |ev, irq)
    endtask

    // Control write with the flag, event and pulse bookkeeping
    task automatic wr_ctrl(input logic [7:0] d);
        logic nd;
        wr(dbg_ctl_pkg::OFS_CTRL, d);
        nd = d[7] ? 1'b1 : ((rpo && gate) ? dbg : 1'b0);
        if (nd && !dbg)
            ev[1] = 1'b1;
        if (!nd && dbg)
            ev[2] = 1'b1;
        dbg = nd;
        bpe = d[6];
        acke = d[5];
        if (d[0])
        begin
            ev[3] = 1'b1;
            exp_pulses++;
        end
        chk_out();
    endtask

    task automatic breakpoint_opcode(input logic [7:0] code);
        @(posedge clk);
        op <= '{valid: 1'b1, code: code};
        @(posedge clk);
        op.valid <= 1'b0;
        #1;
        if (code == dbg_ctl_pkg::BREAKPOINT_OPCODE && bpe)
        begin
            ev[1] = ev[1] | !dbg;
            ev[0] = 1'b1;
            dbg = 1'b1;
            if (acke)
            begin
                ack_q.push_back(dbg_ctl_pkg::ACK_CHAR);
                n_acks++;
            end
        end
        chk_out();
    endtask

    task automatic pulse_chk();
        repeat (RST_CYC + 3) @(posedge clk);
        #1;
        `CHK("reset_len", RST_CYC, last_len)
        `CHK("reset_count", exp_pulses, pulses)
    endtask

    task automatic rd_stat();
        rd(dbg_ctl_pkg::OFS_STAT, {dbg, halt, ~gate, 5'h00});
    endtask

    task automatic rd_events();
        rd(dbg_ctl_pkg::OFS_EVT_STAT, {4'h0, ev});
        ev = 4'h0;
        `CHK("irq", 1'b0, irq)
    endtask

    // Watchdog well beyond the expected run of about 120 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        print_verdict();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        chk_out();
        `CHK("ack_data", dbg_ctl_pkg::ACK_CHAR, ack_data)
        `CHK("device_reset", 1'b0, device_reset)
        rd(dbg_ctl_pkg::OFS_CTRL, dbg_ctl_pkg::CTRL_RESET_VAL);
        // Status follows the live inputs, random combinations
        repeat (8)
        begin
            @(posedge clk);
            halt <= 1'($random(seed));
            gate <= 1'($random(seed));
            #1;
            rd_stat();
        end
        wr(dbg_ctl_pkg::OFS_STAT, 8'hFF);
        wr(dbg_ctl_pkg::OFS_EVT_STAT, 8'h0F);
        rd_stat();
        wr(dbg_ctl_pkg::OFS_EVT_MASK, 8'hFF);
        rd(dbg_ctl_pkg::OFS_EVT_MASK, 8'h0F);
        @(posedge clk);
        gate <= 1'b1;
        wr_ctrl(8'h7E);
        rd(dbg_ctl_pkg::OFS_CTRL, 8'h60);
        breakpoint_opcode(8'h00);
        rd_stat();
        rd_events();
        wr_ctrl(8'h40);
        breakpoint_opcode(8'h01 | 8'($random(seed)));
        breakpoint_opcode(8'h00);
        wr_ctrl(8'h20);
        breakpoint_opcode(8'h00);
        rd_events();
        wr_ctrl(8'h81);
        pulse_chk();
        rd(dbg_ctl_pkg::OFS_CTRL, 8'h80);
        @(posedge clk);
        rpo <= 1'b1;
        wr_ctrl(8'h00);
        wr_ctrl(8'h41);
        pulse_chk();
        rd_stat();
        @(posedge clk);
        gate <= 1'b0;
        wr_ctrl(8'h41);
        pulse_chk();
        wr_ctrl(8'h81);
        wr_ctrl(8'h40);
        pulse_chk();
        rd_events();
        repeat (3) @(posedge clk);
        `CHK("ack_left", 0, ack_q.size())
        `CHK("host_acks", n_acks, ack_count)
        // Mid-run reset must drop a protected debug mode
        @(posedge clk);
        rpo <= 1'b1;
        gate <= 1'b1;
        wr_ctrl(8'h80);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        dbg = 1'b0;
        bpe = 1'b0;
        acke = 1'b0;
        ev = 4'h0;
        @(posedge clk);
        #1;
        chk_out();
        rd(dbg_ctl_pkg::OFS_CTRL, dbg_ctl_pkg::CTRL_RESET_VAL);
        repeat (2) @(posedge clk);
        print_verdict();
    end

endmodule // debugger_control_status_regs_test

`default_nettype wire
